// >>> verilog/cps_regs_map.svh
`ifndef CPS_REGS_MAP_SVH
`define CPS_REGS_MAP_SVH

// ------------------------------------------------
// register indices, byte address is index times four
// ------------------------------------------------
`define CPS_IDX_BANK      8'h04
`define CPS_IDX_PC_LOW    8'h06
`define CPS_IDX_TBL_LO    8'h07
`define CPS_IDX_TBL_LATCH 8'h08
`define CPS_IDX_TBL_HI    8'h09
`define CPS_IDX_STATUS    8'h0A
`define CPS_IDX_IRQ_STAT  8'h10
`define CPS_IDX_IRQ_EN    8'h11
`define CPS_IDX_IRQ_CLR   8'h12
`define CPS_IDX_FIELD     9:2

// ------------------------------------------------
// status bit positions and masks
// ------------------------------------------------
`define CPS_ST_C          0
`define CPS_ST_HALF       1
`define CPS_ST_Z          2
`define CPS_ST_WRAP       3
`define CPS_ST_SLEEP      4
`define CPS_ST_TO         5
`define CPS_ST_ARITH      3:0
`define CPS_ST_SYS        5:4
`define CPS_ST_WR_MASK    8'h0F
`define CPS_ST_IMPL_MASK  8'h3F
`define CPS_BANK_MASK     8'h01

// ------------------------------------------------
// interrupt event bits
// ------------------------------------------------
`define CPS_EV_WDT        0
`define CPS_EV_HALT       1
`define CPS_EV_TBL        2
`define CPS_EV_JUMP       3
`define CPS_EV_W          4

// ------------------------------------------------
// widths and reset values
// ------------------------------------------------
`define CPS_PAGE_W        3
`define CPS_PWORD_W       16
`define CPS_RST_BYTE      8'h00
`define CPS_RST_EV        4'h0
`define CPS_AHB_OKAY      1'b0

`endif

// >>> verilog/cps_pkg.sv
package cps_pkg;

	typedef enum logic [2:0]
	{
		CPS_OP_ADD = 3'h0,
		CPS_OP_SUB = 3'h1,
		CPS_OP_AND = 3'h2,
		CPS_OP_OR  = 3'h3,
		CPS_OP_XOR = 3'h4,
		CPS_OP_RLC = 3'h5,
		CPS_OP_RRC = 3'h6
	} cps_op_t;

	typedef enum logic [0:0]
	{
		CPS_BUS_IDLE = 1'h0,
		CPS_BUS_RD   = 1'h1
	} cps_bus_st_t;

	typedef struct packed
	{
		logic [7:0] res;
		logic [3:0] flags;
	} cps_alu_t;

endpackage : cps_pkg

// >>> verilog/cps_core_regs.sv
`timescale 1ns/1ns
`include "cps_regs_map.svh"

module cps_core_regs
(
	input  wire logic                      CLK_IN,
	input  wire logic                      RST_N_IN,
	input  wire logic                      HSEL_IN,
	input  wire logic [31:0]               HADDR_IN,
	input  wire logic [1:0]                HTRANS_IN,
	input  wire logic                      HWRITE_IN,
	input  wire logic [2:0]                HSIZE_IN,
	input  wire logic [31:0]               HWDATA_IN,
	input  wire logic                      HREADY_IN,
	output logic      [31:0]               HRDATA_OUT,
	output logic                           HREADYOUT_OUT,
	output logic                           HRESP_OUT,
	input  wire logic                      ALU_VALID_IN,
	input  wire logic [2:0]                ALU_OP_IN,
	input  wire logic [7:0]                ALU_A_IN,
	input  wire logic [7:0]                ALU_B_IN,
	output logic      [7:0]                ALU_RESULT_OUT,
	input  wire logic                      HALT_IN,
	input  wire logic                      WDOG_CLEAR_IN,
	input  wire logic                      WDT_TIMEOUT_IN,
	input  wire logic                      SYS_RESET_IN,
	input  wire logic                      RESET_BY_WDT_IN,
	input  wire logic [7:0]                PC_LOW_IN,
	input  wire logic [`CPS_PAGE_W-1:0]    PC_PAGE_IN,
	output logic                           JUMP_OUT,
	output logic      [`CPS_PAGE_W-1:0]    JUMP_PAGE_OUT,
	output logic      [7:0]                JUMP_LOW_OUT,
	output logic                           DUMMY_CYCLE_OUT,
	input  wire logic                      TBL_RD_IN,
	output logic      [15:0]               PMEM_ADDR_OUT,
	input  wire logic [`CPS_PWORD_W-1:0]   PMEM_DATA_IN,
	output logic      [7:0]                TBL_LOW_OUT,
	output logic                           TBL_LOW_VALID_OUT,
	output logic                           DATA_BANK_OUT,
	output logic      [7:0]                STATUS_OUT,
	output logic                           IRQ_OUT
);

	// ------------------------------------------------
	// flag arithmetic
	// ------------------------------------------------
	function automatic cps_pkg::cps_alu_t alu_calc
	(
		input logic [2:0] op,
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [3:0] fl
	);
		cps_pkg::cps_alu_t r;
		logic [7:0]        bb;
		logic [8:0]        s;
		logic [4:0]        n;
		logic [7:0]        s7;
		logic              ci;
		r  = '{res: 8'h00, flags: fl};
		ci = (op == cps_pkg::CPS_OP_SUB);
		bb = ci ? ~b : b;
		s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		n  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		s7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
		case (op)
			cps_pkg::CPS_OP_ADD, cps_pkg::CPS_OP_SUB:
			begin
				r.res                  = s[7:0];
				r.flags[`CPS_ST_C]     = s[8];
				r.flags[`CPS_ST_HALF]  = n[4];
				r.flags[`CPS_ST_WRAP]  = s7[7] ^ s[8];
				r.flags[`CPS_ST_Z]     = (s[7:0] == 8'h00);
			end
			cps_pkg::CPS_OP_AND, cps_pkg::CPS_OP_OR, cps_pkg::CPS_OP_XOR:
			begin
				r.res = (op == cps_pkg::CPS_OP_AND) ? (a & b) :
					(op == cps_pkg::CPS_OP_OR) ? (a | b) : (a ^ b);
				r.flags[`CPS_ST_Z] = (r.res == 8'h00);
			end
			cps_pkg::CPS_OP_RLC:
			begin
				r.res              = {a[6:0], fl[`CPS_ST_C]};
				r.flags[`CPS_ST_C] = a[7];
			end
			cps_pkg::CPS_OP_RRC:
			begin
				r.res              = {fl[`CPS_ST_C], a[7:1]};
				r.flags[`CPS_ST_C] = a[0];
			end
			default:
			begin
				r.res = a;
			end
		endcase
		return r;
	endfunction : alu_calc

	function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
		return idx == want;
	endfunction : idx_hit

	// ------------------------------------------------
	// bus slave state
	// ------------------------------------------------
	cps_pkg::cps_bus_st_t bus_st_r, bus_st_nxt;
	logic [7:0]           rd_idx_r, rd_idx_nxt;
	logic [7:0]           wr_idx_r, wr_idx_nxt;
	logic                 wr_pend_r, wr_pend_nxt;
	logic [31:0]          hrdata_r, hrdata_nxt;
	logic                 hready_r, hready_nxt;
	logic                 take;

	// ------------------------------------------------
	// core register state
	// ------------------------------------------------
	logic [7:0]              bank_r, bank_nxt;
	logic [7:0]              status_r, status_nxt;
	logic [7:0]              pc_low_r, pc_low_nxt;
	logic [7:0]              tbl_lo_r, tbl_lo_nxt;
	logic [7:0]              tbl_hi_r, tbl_hi_nxt;
	logic [7:0]              tbl_latch_r, tbl_latch_nxt;
	logic [7:0]              tbl_out_r, tbl_out_nxt;
	logic                    tbl_vld_r, tbl_vld_nxt;
	logic [7:0]              alu_res_r, alu_res_nxt;
	logic                    jump_r, jump_nxt;
	logic [`CPS_PAGE_W-1:0]  jpage_r, jpage_nxt;
	logic                    dummy_r, dummy_nxt;
	logic [`CPS_EV_W-1:0]    irq_st_r, irq_st_nxt;
	logic [`CPS_EV_W-1:0]    irq_en_r, irq_en_nxt;
	logic                    irq_r, irq_nxt;
	logic [`CPS_EV_W-1:0]    ev;
	cps_pkg::cps_alu_t       alu;
	logic [7:0]              wd;

	// ------------------------------------------------
	// bus next state
	// ------------------------------------------------
	always_comb
	begin
		take        = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
		bus_st_nxt  = bus_st_r;
		rd_idx_nxt  = rd_idx_r;
		wr_idx_nxt  = wr_idx_r;
		wr_pend_nxt = 1'b0;
		hrdata_nxt  = hrdata_r;
		hready_nxt  = 1'b1;
		case (bus_st_r)
			cps_pkg::CPS_BUS_IDLE:
			begin
				if (take && HWRITE_IN)
				begin
					wr_pend_nxt = 1'b1;
					wr_idx_nxt  = HADDR_IN[`CPS_IDX_FIELD];
				end
				else if (take)
				begin
					rd_idx_nxt = HADDR_IN[`CPS_IDX_FIELD];
					hready_nxt = 1'b0;
					bus_st_nxt = cps_pkg::CPS_BUS_RD;
				end
			end
			cps_pkg::CPS_BUS_RD:
			begin
				// reads sample after any preceding write landed
				hrdata_nxt = 32'h0000_0000;
				case (rd_idx_r)
					`CPS_IDX_BANK:      hrdata_nxt[7:0] = bank_r & `CPS_BANK_MASK;
					`CPS_IDX_PC_LOW:    hrdata_nxt[7:0] = pc_low_r;
					`CPS_IDX_TBL_LO:    hrdata_nxt[7:0] = tbl_lo_r;
					`CPS_IDX_TBL_HI:    hrdata_nxt[7:0] = tbl_hi_r;
					`CPS_IDX_TBL_LATCH: hrdata_nxt[7:0] = tbl_latch_r;
					`CPS_IDX_STATUS:    hrdata_nxt[7:0] = status_r & `CPS_ST_IMPL_MASK;
					`CPS_IDX_IRQ_STAT:  hrdata_nxt[`CPS_EV_W-1:0] = irq_st_r;
					`CPS_IDX_IRQ_EN:    hrdata_nxt[`CPS_EV_W-1:0] = irq_en_r;
					default:            hrdata_nxt = 32'h0000_0000;
				endcase
				bus_st_nxt = cps_pkg::CPS_BUS_IDLE;
			end
			default:
			begin
				bus_st_nxt = cps_pkg::CPS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			bus_st_r  <= cps_pkg::CPS_BUS_IDLE;
			rd_idx_r  <= `CPS_RST_BYTE;
			wr_idx_r  <= `CPS_RST_BYTE;
			wr_pend_r <= 1'b0;
			hrdata_r  <= 32'h0000_0000;
			hready_r  <= 1'b1;
		end
		else
		begin
			bus_st_r  <= bus_st_nxt;
			rd_idx_r  <= rd_idx_nxt;
			wr_idx_r  <= wr_idx_nxt;
			wr_pend_r <= wr_pend_nxt;
			hrdata_r  <= hrdata_nxt;
			hready_r  <= hready_nxt;
		end
	end

	// ------------------------------------------------
	// core register next state
	// ------------------------------------------------
	always_comb
	begin
		wd            = HWDATA_IN[7:0];
		alu           = alu_calc(ALU_OP_IN, ALU_A_IN, ALU_B_IN, status_r[`CPS_ST_ARITH]);
		bank_nxt      = bank_r;
		status_nxt    = status_r;
		pc_low_nxt    = PC_LOW_IN;
		tbl_lo_nxt    = tbl_lo_r;
		tbl_hi_nxt    = tbl_hi_r;
		tbl_latch_nxt = tbl_latch_r;
		tbl_out_nxt   = tbl_out_r;
		tbl_vld_nxt   = 1'b0;
		alu_res_nxt   = alu_res_r;
		jump_nxt      = 1'b0;
		jpage_nxt     = jpage_r;
		dummy_nxt     = jump_r;
		irq_en_nxt    = irq_en_r;
		ev            = `CPS_RST_EV;
		if (wr_pend_r)
		begin
			if (idx_hit(wr_idx_r, `CPS_IDX_BANK))
				bank_nxt = wd & `CPS_BANK_MASK;
			if (idx_hit(wr_idx_r, `CPS_IDX_PC_LOW))
			begin
				pc_low_nxt = wd;
				jump_nxt  = 1'b1;
				jpage_nxt = PC_PAGE_IN;
			end
			if (idx_hit(wr_idx_r, `CPS_IDX_TBL_LO))
				tbl_lo_nxt = wd;
			if (idx_hit(wr_idx_r, `CPS_IDX_TBL_HI))
				tbl_hi_nxt = wd;
			if (idx_hit(wr_idx_r, `CPS_IDX_TBL_LATCH))
				tbl_latch_nxt = wd;
			if (idx_hit(wr_idx_r, `CPS_IDX_STATUS))
				status_nxt = (status_r & ~`CPS_ST_WR_MASK) | (wd & `CPS_ST_WR_MASK);
			if (idx_hit(wr_idx_r, `CPS_IDX_IRQ_EN))
				irq_en_nxt = wd[`CPS_EV_W-1:0];
		end
		// status is never stacked; calls leave it untouched
		if (ALU_VALID_IN)
		begin
			status_nxt[`CPS_ST_ARITH] = alu.flags;
			alu_res_nxt     = alu.res;
		end
		if (WDOG_CLEAR_IN)
		begin
			status_nxt[`CPS_ST_SLEEP] = 1'b0;
			status_nxt[`CPS_ST_TO]    = 1'b0;
		end
		else if (HALT_IN)
		begin
			status_nxt[`CPS_ST_SLEEP] = 1'b1;
			status_nxt[`CPS_ST_TO]    = 1'b0;
		end
		if (WDT_TIMEOUT_IN)
			status_nxt[`CPS_ST_TO] = 1'b1;
		if (SYS_RESET_IN && !(RESET_BY_WDT_IN && status_r[`CPS_ST_SLEEP]))
			bank_nxt = `CPS_RST_BYTE;
		if (TBL_RD_IN)
		begin
			tbl_latch_nxt = PMEM_DATA_IN[15:8];
			tbl_out_nxt   = PMEM_DATA_IN[7:0];
			tbl_vld_nxt   = 1'b1;
		end
		ev[`CPS_EV_WDT]  = WDT_TIMEOUT_IN;
		ev[`CPS_EV_HALT] = HALT_IN;
		ev[`CPS_EV_TBL]  = TBL_RD_IN;
		ev[`CPS_EV_JUMP] = jump_nxt;
		irq_st_nxt = irq_st_r;
		if (wr_pend_r && idx_hit(wr_idx_r, `CPS_IDX_IRQ_CLR))
			irq_st_nxt = irq_st_r & ~wd[`CPS_EV_W-1:0];
		irq_st_nxt = irq_st_nxt | ev;
		irq_nxt    = |(irq_st_nxt & irq_en_nxt);
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			bank_r      <= `CPS_RST_BYTE;
			status_r    <= `CPS_RST_BYTE;
			pc_low_r    <= `CPS_RST_BYTE;
			tbl_lo_r    <= `CPS_RST_BYTE;
			tbl_hi_r    <= `CPS_RST_BYTE;
			tbl_latch_r <= `CPS_RST_BYTE;
			tbl_out_r   <= `CPS_RST_BYTE;
			tbl_vld_r   <= 1'b0;
			alu_res_r   <= `CPS_RST_BYTE;
			jump_r      <= 1'b0;
			jpage_r     <= '0;
			dummy_r     <= 1'b0;
			irq_st_r    <= `CPS_RST_EV;
			irq_en_r    <= `CPS_RST_EV;
			irq_r       <= 1'b0;
		end
		else
		begin
			bank_r      <= bank_nxt;
			status_r    <= status_nxt;
			pc_low_r    <= pc_low_nxt;
			tbl_lo_r    <= tbl_lo_nxt;
			tbl_hi_r    <= tbl_hi_nxt;
			tbl_latch_r <= tbl_latch_nxt;
			tbl_out_r   <= tbl_out_nxt;
			tbl_vld_r   <= tbl_vld_nxt;
			alu_res_r   <= alu_res_nxt;
			jump_r      <= jump_nxt;
			jpage_r     <= jpage_nxt;
			dummy_r     <= dummy_nxt;
			irq_st_r    <= irq_st_nxt;
			irq_en_r    <= irq_en_nxt;
			irq_r       <= irq_nxt;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	assign HRDATA_OUT        = hrdata_r;
	assign HREADYOUT_OUT     = hready_r;
	assign HRESP_OUT         = `CPS_AHB_OKAY;
	assign ALU_RESULT_OUT    = alu_res_r;
	assign JUMP_OUT          = jump_r;
	assign JUMP_PAGE_OUT     = jpage_r;
	assign JUMP_LOW_OUT      = pc_low_r;
	assign DUMMY_CYCLE_OUT   = dummy_r;
	assign PMEM_ADDR_OUT     = {tbl_hi_r, tbl_lo_r};
	assign TBL_LOW_OUT       = tbl_out_r;
	assign TBL_LOW_VALID_OUT = tbl_vld_r;
	assign DATA_BANK_OUT     = bank_r[0];
	assign STATUS_OUT        = status_r;
	assign IRQ_OUT           = irq_r;

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	AST_PC_LOW_JUMP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr_pend_r && wr_idx_r == `CPS_IDX_PC_LOW) |=> (JUMP_OUT && JUMP_LOW_OUT == $past(HWDATA_IN[7:0])))
		else $error("low pc write did not jump");
	AST_DUMMY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		JUMP_OUT |=> DUMMY_CYCLE_OUT ##1 !DUMMY_CYCLE_OUT)
		else $error("dummy cycle missing after jump");
	AST_TBL_SPLIT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		TBL_RD_IN |=> (tbl_latch_r == $past(PMEM_DATA_IN[15:8]) && TBL_LOW_OUT == $past(PMEM_DATA_IN[7:0])
		&& TBL_LOW_VALID_OUT))
		else $error("table word split wrong");
	AST_BANK_READ: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(bus_st_r == cps_pkg::CPS_BUS_RD && rd_idx_r == `CPS_IDX_BANK) |=> (HRDATA_OUT == {31'h0, DATA_BANK_OUT}))
		else $error("bank read has extra bits");
	AST_STATUS_WR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(wr_pend_r && wr_idx_r == `CPS_IDX_STATUS && !HALT_IN && !WDOG_CLEAR_IN && !WDT_TIMEOUT_IN)
		|=> $stable(STATUS_OUT[`CPS_ST_SYS]))
		else $error("status write changed system flags");
	AST_HALT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(HALT_IN && !WDOG_CLEAR_IN && !WDT_TIMEOUT_IN) |=> (STATUS_OUT[`CPS_ST_SYS] == 2'h1))
		else $error("halt flags wrong");
	AST_WDOG_CLEAR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(WDOG_CLEAR_IN && !WDT_TIMEOUT_IN) |=> (STATUS_OUT[`CPS_ST_SYS] == 2'h0))
		else $error("watchdog clear left flags set");
	AST_TIMEOUT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		WDT_TIMEOUT_IN |=> STATUS_OUT[`CPS_ST_TO])
		else $error("timeout not flagged");
	AST_ADD_CARRY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(ALU_VALID_IN && ALU_OP_IN == cps_pkg::CPS_OP_ADD)
		|=> (STATUS_OUT[`CPS_ST_C] == ((9'($past(ALU_A_IN)) + 9'($past(ALU_B_IN))) > 9'h0FF)))
		else $error("add carry wrong");
	AST_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(ALU_VALID_IN && ALU_OP_IN == cps_pkg::CPS_OP_XOR)
		|=> (STATUS_OUT[`CPS_ST_Z] == ($past(ALU_A_IN) == $past(ALU_B_IN))))
		else $error("zero flag wrong");
	AST_RLC: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(ALU_VALID_IN && ALU_OP_IN == cps_pkg::CPS_OP_RLC)
		|=> (STATUS_OUT[`CPS_ST_C] == $past(ALU_A_IN[7]) && ALU_RESULT_OUT[0] == $past(STATUS_OUT[`CPS_ST_C])))
		else $error("rotate through carry wrong");
	AST_STATUS_TOP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(bus_st_r == cps_pkg::CPS_BUS_RD && rd_idx_r == `CPS_IDX_STATUS) |=> (HRDATA_OUT[7:6] == 2'h0))
		else $error("status top bits not zero");
	AST_BANK_RST: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(SYS_RESET_IN && !RESET_BY_WDT_IN) |=> !DATA_BANK_OUT)
		else $error("bank not reset");
	AST_IRQ: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(|(irq_st_r & irq_en_r) && !wr_pend_r) |=> IRQ_OUT)
		else $error("interrupt level mismatch");

endmodule : cps_core_regs

// >>> sim/cps_core_regs_bench.sv
`timescale 1ns/1ns
`include "cps_regs_map.svh"

module cps_core_regs_bench;

	// ------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [31:0]             haddr = 32'h0;
	logic [1:0]              htrans = 2'h0;
	logic                    hwrite = 1'b0;
	logic [31:0]             hwdata = 32'h0;
	logic [31:0]             hrdata;
	logic                    hready;
	logic                    hresp;
	logic                    alu_valid = 1'b0;
	logic [2:0]              alu_op = 3'h0;
	logic [7:0]              alu_a = 8'h00;
	logic [7:0]              alu_b = 8'h00;
	logic [7:0]              alu_res;
	logic                    wdt_to = 1'b0;
	logic                    wdog_clear = 1'b0;
	logic                    halt = 1'b0;
	logic                    sys_rst = 1'b0;
	logic                    rst_by_wdt = 1'b0;
	logic [7:0]              pc_low = 8'h33;
	logic [`CPS_PAGE_W-1:0]  pc_page = 3'h5;
	logic                    jump;
	logic                    dummy;
	logic [`CPS_PAGE_W-1:0]  jump_page;
	logic [7:0]              jump_low;
	logic                    tbl_rd = 1'b0;
	logic [15:0]             pmem_addr;
	logic [`CPS_PWORD_W-1:0] pmem_data = 16'h0000;
	logic [7:0]              tbl_low;
	logic                    tbl_valid;
	logic                    bank;
	logic [7:0]              status;
	logic                    irq;
	int                      failures = 0;
	int                      total_checks = 0;
	logic [31:0]             rd;
	logic [7:0]              st;
	logic [11:0]             exp_alu;
	logic [18:0]             alu_tab [12] = '{{3'h0, 8'h7F, 8'h01}, {3'h0, 8'hFF, 8'h01}, {3'h0, 8'h08, 8'h08},
		{3'h1, 8'h10, 8'h01}, {3'h1, 8'h01, 8'h02}, {3'h1, 8'h80, 8'h01}, {3'h2, 8'hF0, 8'h0F},
		{3'h3, 8'h00, 8'h05}, {3'h4, 8'hAA, 8'hAA}, {3'h5, 8'h80, 8'h00}, {3'h6, 8'h01, 8'h00},
		{3'h5, 8'h01, 8'h00}};

	always #5 clk = ~clk;

	cps_core_regs u_dut
	(
		.CLK_IN            (clk),
		.RST_N_IN          (rst_n),
		.HSEL_IN           (1'b1),
		.HADDR_IN          (haddr),
		.HTRANS_IN         (htrans),
		.HWRITE_IN         (hwrite),
		.HSIZE_IN          (3'h2),
		.HWDATA_IN         (hwdata),
		.HREADY_IN         (hready),
		.HRDATA_OUT        (hrdata),
		.HREADYOUT_OUT     (hready),
		.HRESP_OUT         (hresp),
		.ALU_VALID_IN      (alu_valid),
		.ALU_OP_IN         (alu_op),
		.ALU_A_IN          (alu_a),
		.ALU_B_IN          (alu_b),
		.ALU_RESULT_OUT    (alu_res),
		.HALT_IN           (halt),
		.WDOG_CLEAR_IN     (wdog_clear),
		.WDT_TIMEOUT_IN    (wdt_to),
		.SYS_RESET_IN      (sys_rst),
		.RESET_BY_WDT_IN   (rst_by_wdt),
		.PC_LOW_IN         (pc_low),
		.PC_PAGE_IN        (pc_page),
		.JUMP_OUT          (jump),
		.JUMP_PAGE_OUT     (jump_page),
		.JUMP_LOW_OUT      (jump_low),
		.DUMMY_CYCLE_OUT   (dummy),
		.TBL_RD_IN         (tbl_rd),
		.PMEM_ADDR_OUT     (pmem_addr),
		.PMEM_DATA_IN      (pmem_data),
		.TBL_LOW_OUT       (tbl_low),
		.TBL_LOW_VALID_OUT (tbl_valid),
		.DATA_BANK_OUT     (bank),
		.STATUS_OUT        (status),
		.IRQ_OUT           (irq)
	);

	// ------------------------------------------------
	// bus and event tasks
	// ------------------------------------------------
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wait_ready;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				failures++;
				$display("ERROR hready expected 1 seen %b", hready);
				close_out();
			end
			@(posedge clk);
		end
	endtask : wait_ready

	task ahb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
		htrans <= 2'h2;
		hwrite <= wr_en;
		haddr <= {22'h0, idx, 2'h0};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : ahb

	task wr(input logic [7:0] idx, input logic [31:0] wd);
		ahb(1'b1, idx, wd);
	endtask : wr

	task rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		ahb(1'b0, idx, 32'h0);
		chk(nm, exp, rd);
	endtask : rdchk

	// order: timeout, watchdog clear, halt, system reset
	task pulse(input logic [3:0] v);
		{wdt_to, wdog_clear, halt, sys_rst} <= v;
		@(posedge clk);
		{wdt_to, wdog_clear, halt, sys_rst} <= 4'h0;
		@(posedge clk);
	endtask : pulse

	task alu(input logic [18:0] t);
		{alu_op, alu_a, alu_b} <= t;
		alu_valid <= 1'b1;
		@(posedge clk);
		alu_valid <= 1'b0;
		@(posedge clk);
	endtask : alu

	// flags as {wrap, zero, half, carry}
	function automatic logic [11:0] ref_alu(input logic [18:0] t, input logic [3:0] f);
		logic [2:0] op;
		logic [7:0] a;
		logic [7:0] bb;
		logic [7:0] r;
		logic       ci;
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] m;
		{op, a, bb} = t;
		ci = (op == 3'h1);
		if (ci)
			bb = ~bb;
		s = {1'b0, a} + {1'b0, bb} + {8'h0, ci};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		m = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h0, ci};
		r = s[7:0];
		case (op)
			3'h2: r = a & bb;
			3'h3: r = a | bb;
			3'h4: r = a ^ bb;
			3'h5: r = {a[6:0], f[0]};
			3'h6: r = {f[0], a[7:1]};
			default: f = {m[7] ^ s[8], 1'b0, n[4], s[8]};
		endcase
		if (op < 3'h5)
			f[2] = (r == 8'h00);
		if (op == 3'h5)
			f[0] = a[7];
		if (op == 3'h6)
			f[0] = a[0];
		return {r, f};
	endfunction : ref_alu

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk("status reset", `CPS_IDX_STATUS, 32'h0);
		rdchk("bank reset", `CPS_IDX_BANK, 32'h0);
		chk("hresp", 32'h0, 32'(hresp));
		wr(`CPS_IDX_BANK, 32'hFF);
		rdchk("bank bits", `CPS_IDX_BANK, 32'h1);
		wr(8'h3F, 32'hFF);
		rdchk("unmapped", 8'h3F, 32'h0);
		wr(`CPS_IDX_STATUS, 32'hFF);
		rdchk("status write", `CPS_IDX_STATUS, 32'h0F);
		pulse(4'h8);
		chk("status timeout", 32'h2F, 32'(status));
		wr(`CPS_IDX_STATUS, 32'h0);
		rdchk("status keep", `CPS_IDX_STATUS, 32'h20);
		pulse(4'h2);
		chk("status halt", 32'h10, 32'(status));
		pulse(4'hC);
		chk("status same cycle", 32'h20, 32'(status));
		pulse(4'h4);
		chk("status clear", 32'h00, 32'(status));
		st = 8'h00;
		for (int i = 0; i < 12; i++)
		begin
			exp_alu = ref_alu(alu_tab[i], st[3:0]);
			alu(alu_tab[i]);
			st[3:0] = exp_alu[3:0];
			chk("alu result", 32'(exp_alu[11:4]), 32'(alu_res));
			chk("alu status", 32'(st), 32'(status));
		end
		pulse(4'h1);
		chk("bank sys reset", 32'h0, 32'(bank));
		wr(`CPS_IDX_BANK, 32'h1);
		pulse(4'h2);
		rst_by_wdt <= 1'b1;
		pulse(4'h1);
		chk("bank wdt sleep", 32'h1, 32'(bank));
		rst_by_wdt <= 1'b0;
		rdchk("pc low follow", `CPS_IDX_PC_LOW, 32'h33);
		wr(`CPS_IDX_PC_LOW, 32'h5A);
		@(posedge clk);
		chk("jump", 32'h1, 32'(jump));
		chk("jump target", 32'h55A, {21'h0, jump_page, jump_low});
		@(posedge clk);
		chk("dummy", 32'h1, {30'h0, jump, dummy});
		wr(`CPS_IDX_TBL_LO, 32'h34);
		wr(`CPS_IDX_TBL_HI, 32'h12);
		repeat (2) @(posedge clk);
		chk("table addr", 32'h1234, 32'(pmem_addr));
		pmem_data <= 16'hABCD;
		tbl_rd <= 1'b1;
		@(posedge clk);
		tbl_rd <= 1'b0;
		@(posedge clk);
		chk("table low", 32'h1CD, {23'h0, tbl_valid, tbl_low});
		rdchk("table latch", `CPS_IDX_TBL_LATCH, 32'hAB);
		wr(`CPS_IDX_TBL_LO, 32'h35);
		repeat (2) @(posedge clk);
		chk("table step", 32'h1235, 32'(pmem_addr));
		chk("irq masked", 32'h0, 32'(irq));
		rdchk("irq status", `CPS_IDX_IRQ_STAT, 32'h0F);
		wr(`CPS_IDX_IRQ_EN, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq on", 32'h1, 32'(irq));
		wr(`CPS_IDX_IRQ_CLR, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, 32'(irq));
		rdchk("irq status clr", `CPS_IDX_IRQ_STAT, 32'h0D);
		rdchk("irq clr reads", `CPS_IDX_IRQ_CLR, 32'h0);
		wr(`CPS_IDX_IRQ_EN, 32'h8);
		repeat (2) @(posedge clk);
		chk("irq jump", 32'h1, 32'(irq));
		wr(`CPS_IDX_IRQ_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq mask", 32'h0, 32'(irq));
		wr(`CPS_IDX_IRQ_CLR, 32'hF);
		rdchk("irq status empty", `CPS_IDX_IRQ_STAT, 32'h0);
		pulse(4'h2);
		chk("bank before power up", 32'h1, 32'(bank));
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("status power up", 32'h0, 32'(status));
		rdchk("bank power up", `CPS_IDX_BANK, 32'h0);
		rdchk("irq power up", `CPS_IDX_IRQ_STAT, 32'h0);
		close_out();
	end

endmodule : cps_core_regs_bench
